// ==== rtl/dfm_pkg.sv ====
// Package for the drive fault monitor: register map, field layouts, timing constants
`default_nettype none
package dfm_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_BLOCK_SEL = 8'h04;
   localparam logic [7:0] REG_BLOCKED_TIME = 8'h08;
   localparam logic [7:0] REG_POS_SPEED = 8'h0c;
   localparam logic [7:0] REG_NEG_SPEED = 8'h10;
   localparam logic [7:0] REG_FAULTS = 8'h14;
   localparam logic [7:0] REG_ACK = 8'h18;
   localparam logic [7:0] REG_VALUE_BASE = 8'h20; // 16 words, record indices 1..16
   localparam logic [7:0] REG_VALUE_LAST = 8'h5c;

   // Control register fields
   localparam int CTRL_EN_BLOCKED = 0;
   localparam int CTRL_EN_NOCUR = 1;
   localparam int CTRL_EN_MOTOR = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Fault bit positions
   localparam int NUM_FAULTS = 8;
   localparam int F_EXT_A = 0;
   localparam int F_EXT_B = 1;
   localparam int F_BLOCKED = 2;
   localparam int F_NOCUR = 3;
   localparam int F_MOTOR = 4;
   localparam int F_OVERSPEED = 5;
   localparam int F_PSECT = 6;
   localparam int F_PWRLOSS = 7;

   // Scaling: quantities are 16-bit fractions where full scale is 2^14 = 100%
   localparam logic [15:0] CUR_1PCT = 16'h00a4;   // 1% of rated converter current
   localparam logic [15:0] SPD_0P4PCT = 16'h0042; // 0.4% of maximum speed
   localparam logic [15:0] SPD_0P5PCT = 16'h0052; // 0.5% margin
   localparam logic [31:0] BLOCKED_TIME_RESET = 32'h0000_0000;
   localparam logic [15:0] SPEED_LIMIT_RESET = 16'h4000;

   // Control cycle and timing
   localparam int CLK_MHZ = 200;
   localparam int CTRL_CYCLE_US = 1000;
   localparam int CTRL_CYCLE_CLKS = CLK_MHZ * CTRL_CYCLE_US;
   localparam int NOCUR_TIME_MS = 500;
   localparam int NOCUR_CYCLES = NOCUR_TIME_MS * 1000 / CTRL_CYCLE_US;

   // Operating states
   typedef enum logic [1:0] {OP_OTHER, OP_PRE_RUN, OP_RUN, OP_POWER_UP} dfm_opstate_e;

   // Drive measurements in one bundle
   typedef struct packed {
      logic limit_pos;
      logic limit_neg;
      logic alpha_at_limit;
      logic [15:0] armature_current;
      logic signed [15:0] actual_speed;
      logic [31:0] motor_i2t;
      logic [31:0] motor_i2t_limit;
      logic [31:0] psect_i2t;
      logic [31:0] psect_i2t_limit;
   } dfm_meas_s;
endpackage
`default_nettype wire

// ==== rtl/dfm_monitor.sv ====
// Drive fault monitor: external, blocked, no-current, overload, overspeed, power-loss faults
// Summary of operation
// - Block A fault on any selected input
// - Block B fault on any selected input
// - Fault value index one, diagnostics 2..16
// - Blocked: limit, current above 1%, speed low
// - Blocked after programmed time, restart on drop
// - No current: angle limit 500 ms, low current
// - Motor overload at i2t level for 110%
// - Overspeed beyond thresholds plus 0.5%
// - Power-section overload at configured i2t limit
// - Power loss with unacked fault at start-up
// - Drive monitors only in run, pre-run
// - Three monitors disabled until enabled
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`default_nettype none
module dfm_monitor (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Drive state and measurements
   input wire logic [1:0] op_state,
   input wire logic [3:0] free_block_a,
   input wire logic [3:0] free_block_b,
   input wire dfm_pkg::dfm_meas_s meas,
   input wire logic [15:0] diag_in [2:16],
   // Power-loss memory, kept by the retentive store outside
   input wire logic unacked_at_power_down,
   input wire logic [7:0] last_fault_code,
   // Fault outputs
   output logic [7:0] fault_active,
   output logic fault_any
);

   logic [31:0] ctrl_r;
   logic [7:0] sel_r; // [3:0] block A mask, [7:4] block B mask
   logic [31:0] blocked_time_r;
   logic [15:0] pos_speed_r;
   logic [15:0] neg_speed_r;
   logic [7:0] fault_r;
   logic [15:0] value_r [1:16];
   logic [17:0] div_r;
   logic tick;
   logic [31:0] blocked_cnt_r;
   logic [15:0] nocur_cnt_r;
   logic started_r;
   logic run_state;
   logic [7:0] raise;
   logic [15:0] raise_val [0:7];
   logic aw_held_r, w_held_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [7:0] ack_pulse;
   logic blocked_cond, nocur_cond;
   logic signed [17:0] spd_ext, pos_lim, neg_lim;

   // Control-cycle enable pulse
   always_ff @(posedge aclk) begin
      if (!aresetn || div_r == 18'(dfm_pkg::CTRL_CYCLE_CLKS - 1)) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 18'h00001;
      end
   end
   assign tick = (div_r == 18'(dfm_pkg::CTRL_CYCLE_CLKS - 1));

   // Drive monitors gated by operating state
   assign run_state = (op_state == dfm_pkg::OP_RUN) || (op_state == dfm_pkg::OP_PRE_RUN);

   // Blocked drive condition
   assign blocked_cond = (meas.limit_pos || meas.limit_neg) &&
      (meas.armature_current > dfm_pkg::CUR_1PCT) &&
      ((meas.actual_speed < $signed(dfm_pkg::SPD_0P4PCT)) &&
       (meas.actual_speed > -$signed(dfm_pkg::SPD_0P4PCT)));
   assign nocur_cond = meas.alpha_at_limit && (meas.armature_current < dfm_pkg::CUR_1PCT);

   // Blocked timer counts control cycles, restarts when any condition drops
   always_ff @(posedge aclk) begin
      if (!aresetn || !blocked_cond || !run_state) begin
         blocked_cnt_r <= '0;
      end else if (tick && blocked_cnt_r != 32'hffff_ffff) begin
         blocked_cnt_r <= blocked_cnt_r + 32'h1;
      end
   end

   // No-current timer
   always_ff @(posedge aclk) begin
      if (!aresetn || !nocur_cond || !run_state) begin
         nocur_cnt_r <= '0;
      end else if (tick && nocur_cnt_r != 16'hffff) begin
         nocur_cnt_r <= nocur_cnt_r + 16'h1;
      end
   end

   // Overspeed thresholds widened by the margin
   assign spd_ext = 18'(meas.actual_speed);
   assign pos_lim = $signed({2'b00, pos_speed_r}) + $signed({2'b00, dfm_pkg::SPD_0P5PCT});
   assign neg_lim = -($signed({2'b00, neg_speed_r}) + $signed({2'b00, dfm_pkg::SPD_0P5PCT}));

   // Raise conditions and their fault values
   always_comb begin
      raise = '0;
      for (int i = 0; i < 8; i++) begin
         raise_val[i] = '0;
      end
      // External faults report the lowest triggering index
      for (int i = 3; i >= 0; i--) begin
         if (free_block_a[i] && sel_r[i]) begin
            raise[dfm_pkg::F_EXT_A] = 1'b1;
            raise_val[dfm_pkg::F_EXT_A] = 16'(i + 1);
         end
         if (free_block_b[i] && sel_r[i + 4]) begin
            raise[dfm_pkg::F_EXT_B] = 1'b1;
            raise_val[dfm_pkg::F_EXT_B] = 16'(i + 1);
         end
      end
      if (run_state) begin
         raise[dfm_pkg::F_BLOCKED] = ctrl_r[dfm_pkg::CTRL_EN_BLOCKED] &&
            (blocked_cnt_r > blocked_time_r);
         raise[dfm_pkg::F_NOCUR] = ctrl_r[dfm_pkg::CTRL_EN_NOCUR] &&
            (nocur_cnt_r > 16'(dfm_pkg::NOCUR_CYCLES));
         raise[dfm_pkg::F_MOTOR] = ctrl_r[dfm_pkg::CTRL_EN_MOTOR] &&
            (meas.motor_i2t >= meas.motor_i2t_limit);
         raise[dfm_pkg::F_OVERSPEED] = (spd_ext > pos_lim) || (spd_ext < neg_lim);
         raise[dfm_pkg::F_PSECT] = meas.psect_i2t >= meas.psect_i2t_limit;
      end
      raise_val[dfm_pkg::F_OVERSPEED] = (spd_ext > pos_lim) ? 16'h0001 : 16'h0002;
      raise_val[dfm_pkg::F_PWRLOSS] = {8'h00, last_fault_code};
   end

   // Start-up check runs once after reset release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         started_r <= 1'b0;
      end else begin
         started_r <= 1'b1;
      end
   end

   // Latched faults; set wins over acknowledge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_r <= '0;
      end else begin
         for (int i = 0; i < dfm_pkg::NUM_FAULTS; i++) begin
            if (raise[i] || (i == dfm_pkg::F_PWRLOSS && !started_r && unacked_at_power_down)) begin
               fault_r[i] <= 1'b1;
            end else if (ack_pulse[i]) begin
               fault_r[i] <= 1'b0;
            end
         end
      end
   end

   // Fault value record: captured at the first raise while nothing is latched
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int k = 1; k <= 16; k++) begin
            value_r[k] <= '0;
         end
      end else if (fault_r == '0) begin
         for (int i = dfm_pkg::NUM_FAULTS - 1; i >= 0; i--) begin
            if (raise[i] || (i == dfm_pkg::F_PWRLOSS && !started_r && unacked_at_power_down)) begin
               value_r[1] <= raise_val[i];
               for (int k = 2; k <= 16; k++) begin
                  value_r[k] <= diag_in[k];
               end
            end
         end
      end
   end

   assign fault_active = fault_r;
   assign fault_any = |fault_r;

   // AXI write channel capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= '0;
      end else if (aw_held_r && w_held_r) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
         end
      end
   end
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;

   // Register writes; byte strobes ignored entirely for simplicity
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= dfm_pkg::CTRL_RESET;
         sel_r <= '0;
         blocked_time_r <= dfm_pkg::BLOCKED_TIME_RESET;
         pos_speed_r <= dfm_pkg::SPEED_LIMIT_RESET;
         neg_speed_r <= dfm_pkg::SPEED_LIMIT_RESET;
      end else if (aw_held_r && w_held_r) begin
         case (aw_addr_r)
            dfm_pkg::REG_CTRL: ctrl_r <= w_data_r;
            dfm_pkg::REG_BLOCK_SEL: sel_r <= w_data_r[7:0];
            dfm_pkg::REG_BLOCKED_TIME: blocked_time_r <= w_data_r;
            dfm_pkg::REG_POS_SPEED: pos_speed_r <= w_data_r[15:0];
            dfm_pkg::REG_NEG_SPEED: neg_speed_r <= w_data_r[15:0];
            default: ;
         endcase
      end
   end
   assign ack_pulse = (aw_held_r && w_held_r && aw_addr_r == dfm_pkg::REG_ACK) ? w_data_r[7:0] : 8'h00;

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (aw_held_r && w_held_r) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr_r <= dfm_pkg::REG_ACK) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel, one cycle after address taken
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         case (s_axi_araddr)
            dfm_pkg::REG_CTRL: s_axi_rdata <= ctrl_r;
            dfm_pkg::REG_BLOCK_SEL: s_axi_rdata <= {24'h0, sel_r};
            dfm_pkg::REG_BLOCKED_TIME: s_axi_rdata <= blocked_time_r;
            dfm_pkg::REG_POS_SPEED: s_axi_rdata <= {16'h0, pos_speed_r};
            dfm_pkg::REG_NEG_SPEED: s_axi_rdata <= {16'h0, neg_speed_r};
            dfm_pkg::REG_FAULTS: s_axi_rdata <= {24'h0, fault_r};
            dfm_pkg::REG_ACK: s_axi_rdata <= '0;
            default: begin
               if (s_axi_araddr >= dfm_pkg::REG_VALUE_BASE && s_axi_araddr <= dfm_pkg::REG_VALUE_LAST &&
                   s_axi_araddr[1:0] == 2'b00) begin
                  s_axi_rdata <= {16'h0, value_r[5'(((s_axi_araddr - dfm_pkg::REG_VALUE_BASE) >> 2) + 8'h01)]};
               end else begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= 2'b10;
               end
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // dfm_monitor
`default_nettype wire

// ==== sim/dfm_monitor_sva.sv ====
// Port-level checker for the drive fault monitor
`default_nettype none
module dfm_monitor_sva (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Drive side
   input wire logic [1:0] op_state,
   input wire logic [3:0] free_block_a,
   input wire logic [3:0] free_block_b,
   input wire dfm_pkg::dfm_meas_s meas,
   input wire logic unacked_at_power_down,
   // Faults
   input wire logic [7:0] fault_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // A fault may only rise when its cause was present one or two cycles before
   a_ext_a_cause: assert property ($rose(fault_active[0]) |-> $past(|free_block_a) || $past(|free_block_a, 2))
      else $error("block a fault without selected input");
   a_ext_b_cause: assert property ($rose(fault_active[1]) |-> $past(|free_block_b) || $past(|free_block_b, 2))
      else $error("block b fault without selected input");
   a_drive_gated: assert property (|(fault_active[6:2] & ~$past(fault_active[6:2])) |->
      $past(op_state) == 2'h1 || $past(op_state) == 2'h2) else $error("drive fault outside run states");
   a_motor_cause: assert property ($rose(fault_active[4]) |-> $past(meas.motor_i2t >= meas.motor_i2t_limit))
      else $error("motor overload without i2t level");
   a_psect_cause: assert property ($rose(fault_active[6]) |-> $past(meas.psect_i2t >= meas.psect_i2t_limit))
      else $error("power section overload without i2t level");
   // Latched bits drop only through an acknowledge write
   a_latch_hold: assert property (|($past(fault_active) & ~fault_active) |-> ##[0:1] s_axi_bvalid)
      else $error("fault cleared without a write");
   a_pwr_set: assert property ($rose(aresetn) && unacked_at_power_down |=> fault_active[7])
      else $error("power loss fault missing at start");
   a_pwr_start_only: assert property ($rose(fault_active[7]) |-> !$past(aresetn, 2))
      else $error("power loss fault away from start");
   a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
      ##[2:3] s_axi_bvalid) else $error("write response late");
   a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
endmodule // dfm_monitor_sva

bind dfm_monitor dfm_monitor_sva i_dfm_monitor_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .op_state,
   .free_block_a, .free_block_b, .meas, .unacked_at_power_down, .fault_active);
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the drive fault monitor
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [1:0] op;
      logic [3:0] a;
      logic [3:0] b;
      logic [15:0] spd;
      logic men;
      logic mot;
      logic ps;
      logic [7:0] mask;
      logic [31:0] val;
   } dfm_row_s;
   // Bus and drive stimulus
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, fault_any;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, d;
   logic [1:0] r;
   logic [1:0] op = 2'h0;
   logic [3:0] fa = 4'h0, fb = 4'h0;
   dfm_pkg::dfm_meas_s meas = '0;
   logic [15:0] diag [2:16];
   logic unacked = 1'b0;
   logic [7:0] fault_active;
   int error_cnt = 0, num_checks = 0, cyc = 0;
   // Ordinary cases: inputs, then the fault bits and value they should give
   dfm_row_s rows [12] = '{
      '{2'h0, 4'h4, 4'h0, 16'h0000, 1'b0, 1'b0, 1'b0, 8'h01, 32'h3},
      '{2'h0, 4'h6, 4'h0, 16'h0000, 1'b0, 1'b0, 1'b0, 8'h01, 32'h2},
      '{2'h3, 4'h0, 4'h8, 16'h0000, 1'b0, 1'b0, 1'b0, 8'h02, 32'h4},
      '{2'h2, 4'h0, 4'h1, 16'h0000, 1'b0, 1'b0, 1'b0, 8'h02, 32'h1},
      '{2'h2, 4'h0, 4'h0, 16'h1060, 1'b0, 1'b0, 1'b0, 8'h20, 32'h1},
      '{2'h1, 4'h0, 4'h0, 16'hefa0, 1'b0, 1'b0, 1'b0, 8'h20, 32'h2},
      '{2'h2, 4'h0, 4'h0, 16'h1040, 1'b0, 1'b0, 1'b0, 8'h00, 32'h0},
      '{2'h0, 4'h0, 4'h0, 16'h1060, 1'b0, 1'b0, 1'b0, 8'h00, 32'h0},
      '{2'h2, 4'h0, 4'h0, 16'h0000, 1'b0, 1'b1, 1'b0, 8'h00, 32'h0},
      '{2'h2, 4'h0, 4'h0, 16'h0000, 1'b1, 1'b1, 1'b0, 8'h10, 32'h0},
      '{2'h1, 4'h0, 4'h0, 16'h0000, 1'b0, 1'b0, 1'b1, 8'h40, 32'h0},
      '{2'h0, 4'h0, 4'h0, 16'h0000, 1'b0, 1'b0, 1'b1, 8'h00, 32'h0}};

   dfm_monitor i_dfm_monitor (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .op_state(op), .free_block_a(fa),
      .free_block_b(fb), .meas(meas), .diag_in(diag), .unacked_at_power_down(unacked),
      .last_fault_code(8'h5a), .fault_active(fault_active), .fault_any(fault_any));

   // 200 MHz clock
   initial begin
      forever #2.5 aclk = ~aclk;
   end

   // Hang guard, far above the several hundred cycles the run needs
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: response %b, expected %b", $time, got, exp);
      end
   endtask

   // Ready is looked at on the falling edge, so the taking rising edge is the next one
   task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic ta, tw, pa, pw;
      ta = 1'b1;
      tw = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (ta || tw) begin
         @(negedge aclk);
         pa = ta && awready === 1'b1;
         pw = tw && wready === 1'b1;
         @(posedge aclk);
         if (pa) awvalid <= 1'b0;
         if (pw) wvalid <= 1'b0;
         ta = ta && !pa;
         tw = tw && !pw;
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      rs = bresp;
      @(posedge aclk) bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk) arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      @(posedge aclk) rready <= 1'b0;
   endtask

   // Bounded wait for the expected fault bits; an empty mask just lets time pass
   task automatic wait_fault(input logic [7:0] m);
      for (int n = 0; n < 40; n++) begin
         @(negedge aclk);
         if (m != 8'h00 && (fault_active & m) === m) break;
      end
   endtask

   // Main sequence
   initial begin
      for (int k = 2; k <= 16; k++) diag[k] = 16'h1000 + 16'(k);
      meas.motor_i2t_limit = 32'h100;
      meas.psect_i2t_limit = 32'h100;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axi_read(dfm_pkg::REG_CTRL, d, r);
      chk_val(d, dfm_pkg::CTRL_RESET);
      axi_write(dfm_pkg::REG_BLOCK_SEL, 32'hff, r);
      axi_write(dfm_pkg::REG_POS_SPEED, 32'h1000, r);
      axi_write(dfm_pkg::REG_NEG_SPEED, 32'h1000, r);
      foreach (rows[i]) begin
         axi_write(dfm_pkg::REG_CTRL, rows[i].men ? 32'h4 : 32'h0, r);
         @(posedge aclk);
         op <= rows[i].op;
         fa <= rows[i].a;
         fb <= rows[i].b;
         meas.actual_speed <= rows[i].spd;
         meas.motor_i2t <= rows[i].mot ? 32'h100 : 32'h0;
         meas.psect_i2t <= rows[i].ps ? 32'h100 : 32'h0;
         wait_fault(rows[i].mask);
         chk_val({24'h0, fault_active}, {24'h0, rows[i].mask});
         chk_val({31'h0, fault_any}, {31'h0, |rows[i].mask});
         if (rows[i].mask != 8'h00) begin
            axi_read(dfm_pkg::REG_VALUE_BASE, d, r);
            chk_val(d, rows[i].val);
            chk_resp(r, 2'b00);
            axi_read(dfm_pkg::REG_VALUE_LAST, d, r);
            chk_val(d, 32'h1010);
         end
         // Cause removed before the acknowledge, since a standing cause wins
         @(posedge aclk);
         fa <= 4'h0;
         fb <= 4'h0;
         meas.actual_speed <= 16'h0;
         meas.motor_i2t <= 32'h0;
         meas.psect_i2t <= 32'h0;
         repeat (4) @(posedge aclk);
         chk_val({24'h0, fault_active}, {24'h0, rows[i].mask});
         axi_write(dfm_pkg::REG_ACK, 32'hff, r);
         chk_resp(r, 2'b00);
         @(negedge aclk);
         chk_val({24'h0, fault_active}, 32'h0);
      end
      // Unmapped place refused both ways
      axi_read(8'hfc, d, r);
      chk_resp(r, 2'b10);
      chk_val(d, 32'h0);
      axi_write(8'hfc, 32'h1, r);
      chk_resp(r, 2'b10);
      // Second reset with an unacknowledged fault remembered outside
      @(posedge aclk);
      unacked <= 1'b1;
      op <= 2'h3;
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      wait_fault(8'h80);
      chk_val({24'h0, fault_active}, 32'h80);
      axi_read(dfm_pkg::REG_VALUE_BASE, d, r);
      chk_val(d, 32'h5a);
      axi_read(dfm_pkg::REG_POS_SPEED, d, r);
      chk_val(d, {16'h0, dfm_pkg::SPEED_LIMIT_RESET});
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
